//--- lp_detect_pkg.sv
// Shared constants for the low-power detector configuration register bank
package lp_detect_pkg;
	// Register indices; the byte address is four times the index
	localparam logic [5:0] IDX_IRQ_MERGE = 6'h0f;
	localparam logic [5:0] IDX_DET_CTRL = 6'h10;
	localparam logic [5:0] IDX_DET_TH1 = 6'h11;
	localparam logic [5:0] IDX_DET_TH2 = 6'h12;
	localparam logic [5:0] IDX_DET_TH3 = 6'h13;
	localparam logic [5:0] IDX_IDC_A = 6'h14;
	localparam logic [5:0] IDX_IDC_B = 6'h15;
	localparam logic [5:0] IDX_IDC_C = 6'h16;
	// Number of registers and detector registers
	localparam int NUM_REGS = 8;
	localparam int NUM_DET = 4;
	// Slot of each register in the bank (index minus first index)
	localparam logic [2:0] SLOT_IRQ_MERGE = 3'h0;
	localparam logic [2:0] SLOT_DET_CTRL = 3'h1;
	localparam logic [2:0] SLOT_DET_TH3 = 3'h4;
	localparam logic [2:0] SLOT_IDC_A = 3'h5;
	localparam logic [2:0] SLOT_IDC_B = 3'h6;
	localparam logic [2:0] SLOT_IDC_C = 3'h7;
	// Field positions
	localparam int BIT_SECOND_IRQ_MERGE_BIT = 0;
	localparam int BIT_WARN_OR = 1;
	localparam int BIT_CAL_EN = 6;
	localparam int PD_MSB = 5;
	localparam int NEG_MSB = 15;
	localparam int NEG_LSB = 8;
	localparam int POS_MSB = 7;
	localparam int POS_LSB = 0;
	// Writable bit masks
	localparam logic [15:0] MASK_IRQ_MERGE = 16'h0003;
	localparam logic [15:0] MASK_FULL = 16'hffff;
	// Reset values of the software-visible copies
	localparam logic [15:0] RST_REG = 16'h0000;
	// AXI response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Register width on the bus
	localparam int REG_W = 16;
endpackage : lp_detect_pkg

//--- detector_latch_if.sv
// Carrier between the register bank and the detector configuration latches
interface detector_latch_if;
	logic load; // One-cycle strobe: copy all words
	logic [3:0][15:0] word; // Software copies of the four detector registers
	logic [3:0][15:0] latched; // Contents of the detector latches
	modport bank (input load, input word, output latched);
	modport ctrl (output load, output word, input latched);
endinterface : detector_latch_if

//--- detector_latch_bank.sv
// Detector configuration latches with no reset
module detector_latch_bank
(
	input wire logic aclk,
	input wire logic ce,
	detector_latch_if.bank lat
);
	import lp_detect_pkg::*;

	// Latch storage; deliberately without reset so it survives every reset and mode
	logic [3:0][15:0] cfg_ff;

	// All four words are copied together on any load
	always_ff @(posedge aclk)
	begin
		if (ce && lat.load)
		begin
			cfg_ff <= lat.word;
		end
	end

	assign lat.latched = cfg_ff;
endmodule : detector_latch_bank

//--- low_power_detect_config_regs.sv
// AXI4-Lite register bank for detector configuration, interrupt merge and current offsets
// Behaviour
// - Warning merge bit ORs warning into first interrupt
// - Second merge bit ORs second interrupt into first
// - Any detector register write copies all four
// - Detector latches ignore reset, persist across modes
// - Control bit six enables normal-mode calibration
// - Calibration routes detectors onto both interrupt pins
// - Control bits power down negative/positive detectors
// - Threshold: negative code high, positive low
// - Eight-bit code maps linearly onto level
// - Per-phase signed current offset feeds decimator
module low_power_detect_config_regs
#(
	parameter int ADDR_W = 8
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// AXI4-Lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	// AXI4-Lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	// AXI4-Lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Interrupt sources from the rest of the device
	input wire logic normal_first_interrupt_output_in,
	input wire logic normal_second_interrupt_output_in,
	input wire logic warn_in,
	input wire logic det_first_interrupt_output_in,
	input wire logic det_second_interrupt_output_in,
	input wire logic detect_mode_in,
	// Interrupt pins
	output logic first_interrupt_output,
	output logic second_interrupt_output,
	// Analog detector controls
	output logic detector_enable,
	output logic detector_calibration_enable,
	output logic [5:0] detector_powerdown,
	output logic [23:0] negative_threshold_code,
	output logic [23:0] positive_threshold_code,
	// Decimator offsets
	output logic [15:0] phase_a_current_dc_offset,
	output logic [15:0] phase_b_current_dc_offset,
	output logic [15:0] phase_c_current_dc_offset
);
	import lp_detect_pkg::*;

	// Merge new data into a register under the low two byte strobes
	function automatic logic [15:0] apply_strb(input logic [15:0] old, input logic [15:0] val,
		input logic [3:0] strb, input logic [15:0] mask);
		logic [15:0] merged;
		merged = old;
		if (strb[0])
		begin
			merged[7:0] = val[7:0];
		end
		if (strb[1])
		begin
			merged[15:8] = val[15:8];
		end
		apply_strb = merged & mask;
	endfunction : apply_strb

	// Turn a byte address into a bank slot and a hit flag
	function automatic logic [3:0] decode(input logic [ADDR_W-1:0] addr);
		logic [5:0] idx;
		logic [5:0] rel;
		idx = addr[7:2];
		rel = idx - IDX_IRQ_MERGE;
		if (addr[1:0] == 2'h0 && idx >= IDX_IRQ_MERGE && idx <= IDX_IDC_C)
		begin
			decode = {1'b1, rel[2:0]};
		end
		else
		begin
			decode = 4'h0;
		end
	endfunction : decode

	// Writable mask of each slot; reserved bits stay zero
	function automatic logic [15:0] slot_mask(input logic [2:0] slot);
		slot_mask = (slot == SLOT_IRQ_MERGE) ? MASK_IRQ_MERGE : MASK_FULL;
	endfunction : slot_mask

	// Software-visible register copies
	logic [15:0] regs_ff [NUM_REGS];

	// Write channel state
	logic awready_ff;
	logic wready_ff;
	logic aw_held_ff;
	logic w_held_ff;
	logic [ADDR_W-1:0] awaddr_ff;
	logic [15:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;

	// Read channel state
	logic arready_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;

	// Latch load strobe, raised on the same edge as the register copy changes
	logic load_ff;

	// Registered interrupt and detector outputs
	logic first_interrupt_output_ff;
	logic second_interrupt_output_ff;
	logic det_en_ff;

	// Detector latch carrier
	detector_latch_if lat ();

	// Write decode
	wire logic aw_take = awvalid && awready_ff;
	wire logic w_take = wvalid && wready_ff;
	wire logic do_write = aw_held_ff && w_held_ff && !bvalid_ff;
	wire logic [3:0] wr_dec = decode(awaddr_ff);
	wire logic wr_hit = wr_dec[3];
	wire logic [2:0] wr_slot = wr_dec[2:0];
	wire logic wr_det = wr_hit && wr_slot >= SLOT_DET_CTRL && wr_slot <= SLOT_DET_TH3;

	// Read decode
	wire logic ar_take = arvalid && arready_ff;
	wire logic [3:0] rd_dec = decode(araddr);
	wire logic rd_hit = rd_dec[3];
	wire logic [15:0] rd_word = rd_hit ? regs_ff[rd_dec[2:0]] : RST_REG;

	// Interrupt routing; the detectors take over the pins in detect mode or calibration
	wire logic [15:0] det_ctrl_lat = lat.latched[0];
	wire logic cal_en = det_ctrl_lat[BIT_CAL_EN];
	wire logic det_route = cal_en || detect_mode_in;
	wire logic second_interrupt_output_src = det_route ? det_second_interrupt_output_in : normal_second_interrupt_output_in;
	wire logic first_interrupt_output_base = det_route ? det_first_interrupt_output_in : normal_first_interrupt_output_in;
	wire logic warn_or = regs_ff[SLOT_IRQ_MERGE][BIT_WARN_OR];
	wire logic second_irq_merge_bit = regs_ff[SLOT_IRQ_MERGE][BIT_SECOND_IRQ_MERGE_BIT];
	wire logic nxt_first_interrupt_output = first_interrupt_output_base || (warn_or && warn_in) || (second_irq_merge_bit && second_interrupt_output_src);

	// Write address and data are taken independently and held until the write retires
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_ff <= 1'b1;
			wready_ff <= 1'b1;
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff <= RST_REG;
			wstrb_ff <= 4'h0;
		end
		else if (ce)
		begin
			if (aw_take)
			begin
				awaddr_ff <= awaddr;
				aw_held_ff <= 1'b1;
				awready_ff <= 1'b0;
			end
			if (w_take)
			begin
				wdata_ff <= wdata[15:0];
				wstrb_ff <= wstrb;
				w_held_ff <= 1'b1;
				wready_ff <= 1'b0;
			end
			if (do_write)
			begin
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
			end
			// Reopen both channels only once the response is gone
			if (bvalid_ff && bready)
			begin
				awready_ff <= 1'b1;
				wready_ff <= 1'b1;
			end
		end
	end

	// Write response; unmapped addresses get a slave error
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end
		else if (ce)
		begin
			if (do_write)
			begin
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid_ff && bready)
			begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// Register copies; the offsets go straight to the decimator
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < NUM_REGS; i++)
			begin
				regs_ff[i] <= RST_REG;
			end
		end
		else if (ce && do_write && wr_hit)
		begin
			regs_ff[wr_slot] <= apply_strb(regs_ff[wr_slot], wdata_ff, wstrb_ff, slot_mask(wr_slot));
		end
	end

	// Load strobe follows the write, so the latches see the updated copy
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			load_ff <= 1'b0;
		end
		else if (ce)
		begin
			load_ff <= do_write && wr_det;
		end
	end

	// Read channel: data registered on the same edge that takes the address
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= RESP_OKAY;
		end
		else if (ce)
		begin
			if (ar_take)
			begin
				arready_ff <= 1'b0;
				rvalid_ff <= 1'b1;
				rdata_ff <= {16'h0000, rd_word};
				rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (rvalid_ff && rready)
			begin
				rvalid_ff <= 1'b0;
				arready_ff <= 1'b1;
			end
		end
	end

	// Interrupt pins and detector enable, registered to keep the pins glitch free
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			first_interrupt_output_ff <= 1'b0;
			second_interrupt_output_ff <= 1'b0;
			det_en_ff <= 1'b0;
		end
		else if (ce)
		begin
			first_interrupt_output_ff <= nxt_first_interrupt_output;
			second_interrupt_output_ff <= second_interrupt_output_src;
			det_en_ff <= det_route;
		end
	end

	// Words offered to the latches, in detector register order
	assign lat.load = load_ff;
	assign lat.word[0] = regs_ff[SLOT_DET_CTRL];
	assign lat.word[1] = regs_ff[SLOT_DET_CTRL + 3'h1];
	assign lat.word[2] = regs_ff[SLOT_DET_CTRL + 3'h2];
	assign lat.word[3] = regs_ff[SLOT_DET_TH3];

	// Latch bank; its outputs survive reset, so detector pins may be unknown until programmed
	detector_latch_bank u_latch (
		.aclk(aclk),
		.ce(ce),
		.lat(lat.bank)
	);

	// Bus outputs
	assign awready = awready_ff;
	assign wready = wready_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign arready = arready_ff;
	assign rvalid = rvalid_ff;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;

	// Interrupt and detector outputs
	assign first_interrupt_output = first_interrupt_output_ff;
	assign second_interrupt_output = second_interrupt_output_ff;
	assign detector_enable = det_en_ff;
	assign detector_calibration_enable = lat.latched[0][BIT_CAL_EN];
	assign detector_powerdown = lat.latched[0][PD_MSB:0];

	// Threshold codes: channel 1 in the low byte of each bus, codes passed linearly to the DAC
	assign negative_threshold_code = {lat.latched[3][NEG_MSB:NEG_LSB], lat.latched[2][NEG_MSB:NEG_LSB],
		lat.latched[1][NEG_MSB:NEG_LSB]};
	assign positive_threshold_code = {lat.latched[3][POS_MSB:POS_LSB], lat.latched[2][POS_MSB:POS_LSB],
		lat.latched[1][POS_MSB:POS_LSB]};

	// Signed offsets, two's complement, handed to each phase's decimator
	assign phase_a_current_dc_offset = regs_ff[SLOT_IDC_A];
	assign phase_b_current_dc_offset = regs_ff[SLOT_IDC_B];
	assign phase_c_current_dc_offset = regs_ff[SLOT_IDC_C];
endmodule : low_power_detect_config_regs

//--- low_power_detect_config_regs_props.sv
// Assertions on the ports of the detector configuration register bank
module low_power_detect_config_regs_props
import lp_detect_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic [31:0] rdata,
	input wire logic normal_first_interrupt_output_in,
	input wire logic normal_second_interrupt_output_in,
	input wire logic warn_in,
	input wire logic det_first_interrupt_output_in,
	input wire logic det_second_interrupt_output_in,
	input wire logic detect_mode_in,
	input wire logic first_interrupt_output,
	input wire logic second_interrupt_output,
	input wire logic detector_enable,
	input wire logic detector_calibration_enable,
	input wire logic [5:0] detector_powerdown,
	input wire logic [23:0] negative_threshold_code,
	input wire logic [23:0] positive_threshold_code
);
	import lp_detect_pkg::*;
	// Routing seen at the pins; unknown until the latches are first loaded
	wire route = detector_calibration_enable | detect_mode_in;
	wire base = route ? det_first_interrupt_output_in : normal_first_interrupt_output_in;
	wire irq1src = route ? det_second_interrupt_output_in : normal_second_interrupt_output_in;
	// All latch outputs together
	wire [54:0] lat = {detector_calibration_enable, detector_powerdown, negative_threshold_code,
		positive_threshold_code};
	// Word index of the write address
	wire [ADDR_W-1:0] aw_idx = awaddr >> 2;
	wire aw_map = awaddr[1:0] == 2'h0 && aw_idx >= ADDR_W'(IDX_IRQ_MERGE) && aw_idx <= ADDR_W'(IDX_IDC_C);
	wire aw_det = awaddr[1:0] == 2'h0 && aw_idx >= ADDR_W'(IDX_DET_CTRL) && aw_idx <= ADDR_W'(IDX_DET_TH3);
	// Last taken write address hit a detector register
	logic det_aw_ff = 1'b0;
	// Latches power up undefined, so hold checks wait for the first detector write to answer
	// Deliberately not cleared by reset, so the hold check also spans a reset
	logic seen_ff = 1'b0;
	always @(posedge aclk)
	begin
		if (ce && awvalid && awready)
			det_aw_ff <= aw_det;
		if (bvalid && det_aw_ff)
			seen_ff <= 1'b1;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_take; ce && awvalid && awready && wvalid && wready; endsequence
	sequence s_bad_wr; s_wr_take ##0 !aw_map; endsequence
	property p_quiet_irq; ce && !base && !warn_in && !irq1src |=> !first_interrupt_output; endproperty
	a_quiet_irq: assert property (p_quiet_irq) else $error("first interrupt without source");
	property p_base_irq; ce && base |=> first_interrupt_output; endproperty
	a_base_irq: assert property (p_base_irq) else $error("first interrupt missed its base");
	property p_second_hi; ce && irq1src |=> second_interrupt_output; endproperty
	a_second_hi: assert property (p_second_hi) else $error("second interrupt missed");
	property p_second_lo; ce && !irq1src |=> !second_interrupt_output; endproperty
	a_second_lo: assert property (p_second_lo) else $error("second interrupt spurious");
	property p_det_enable; ce && route |=> detector_enable; endproperty
	a_det_enable: assert property (p_det_enable) else $error("detectors not enabled");
	property p_latch_hold; seen_ff && !$past(bvalid) |-> $stable(lat); endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latches moved without a write");
	// Response rises one enabled edge after both halves are held
	property p_write_resp; s_wr_take |=> ((!awready && !wready) and (ce |=> bvalid)); endproperty
	a_write_resp: assert property (p_write_resp) else $error("write response late");
	property p_slverr; s_bad_wr ##1 ce |=> bresp == RESP_SLVERR; endproperty
	a_slverr: assert property (p_slverr) else $error("unmapped write not refused");
	property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_read_resp; ce && arvalid && arready |=> rvalid && !arready && rdata[31:16] == 16'h0; endproperty
	a_read_resp: assert property (p_read_resp) else $error("read answer wrong");
endmodule : low_power_detect_config_regs_props

bind low_power_detect_config_regs low_power_detect_config_regs_props #(.ADDR_W(ADDR_W)) chk (.aclk, .aresetn,
	.ce, .awvalid, .awready, .awaddr, .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid,
	.rdata, .normal_first_interrupt_output_in, .normal_second_interrupt_output_in, .warn_in, .det_first_interrupt_output_in, .det_second_interrupt_output_in, .detect_mode_in,
	.first_interrupt_output, .second_interrupt_output, .detector_enable, .detector_calibration_enable,
	.detector_powerdown, .negative_threshold_code, .positive_threshold_code);

//--- low_power_detect_config_regs_tb.sv
// Self-checking bench for the detector configuration register bank
module low_power_detect_config_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import lp_detect_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic ce = 1'b1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0;
	logic [31:0] wdata = 32'h0;
	logic [5:0] src = 6'h0; // Mode, normal 0/1, warning, detector 0/1
	logic awready, wready, bvalid, arready, rvalid, first, second, den, cal;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, d;
	logic [1:0] r;
	logic [5:0] pd;
	logic [23:0] neg, pos;
	logic [15:0] offa, offb, offc;
	int n_mismatch = 0;
	int tests_run = 0;
	int cycles = 0;
	always #5 aclk = ~aclk;
	low_power_detect_config_regs uut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.normal_first_interrupt_output_in(src[4]), .normal_second_interrupt_output_in(src[3]), .warn_in(src[2]), .det_first_interrupt_output_in(src[1]),
		.det_second_interrupt_output_in(src[0]), .detect_mode_in(src[5]), .first_interrupt_output(first),
		.second_interrupt_output(second), .detector_enable(den), .detector_calibration_enable(cal),
		.detector_powerdown(pd), .negative_threshold_code(neg), .positive_threshold_code(pos),
		.phase_a_current_dc_offset(offa), .phase_b_current_dc_offset(offb), .phase_c_current_dc_offset(offc));
	task final_report;
		if (n_mismatch == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report
	// Hang guard, far above the expected run length
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			n_mismatch++;
			final_report();
		end
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (e !== g)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// One write; address and data released as each is taken
	task wr(input logic [7:0] a, input logic [15:0] v, input logic [1:0] er);
		awaddr <= a;
		wdata <= {16'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		chk("bresp", 32'(er), 32'(bresp));
		bready <= 1'b0;
		@(posedge aclk);
	endtask : wr
	// One read with expected data and response
	task rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
		chk("rdata", e, d);
		chk("rresp", 32'(er), 32'(r));
	endtask : rdc
	task lat(input logic c, input logic [5:0] p, input logic [23:0] n, input logic [23:0] q);
		chk("cal", 32'(c), 32'(cal));
		chk("powerdown", 32'(p), 32'(pd));
		chk("neg", 32'(n), 32'(neg));
		chk("pos", 32'(q), 32'(pos));
	endtask : lat
	// Every merge setting against every source pattern
	task sweep(input logic c);
		logic rt, i1, f;
		for (int m = 0; m < 4; m++)
		begin
			wr(8'h3c, 16'(m), RESP_OKAY);
			for (int k = 0; k < 64; k++)
			begin
				src <= 6'(k);
				@(posedge aclk);
				@(posedge aclk);
				rt = c | src[5];
				i1 = rt ? src[0] : src[3];
				f = (rt ? src[1] : src[4]) | (m[1] & src[2]) | (m[0] & i1);
				chk("first", 32'(f), 32'(first));
				chk("second", 32'(i1), 32'(second));
				chk("det_enable", 32'(rt), 32'(den));
			end
		end
	endtask : sweep
	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 8; i++)
			rdc(8'h3c + 8'(4 * i), 32'h0, RESP_OKAY);
		rdc(8'h5c, 32'h0, RESP_SLVERR);
		rdc(8'h41, 32'h0, RESP_SLVERR);
		wr(8'h5c, 16'h1234, RESP_SLVERR);
		wr(8'h3c, 16'hffff, RESP_OKAY);
		rdc(8'h3c, 32'h3, RESP_OKAY);
		wr(8'h40, 16'h01aa, RESP_OKAY);
		lat(1'b0, 6'h2a, 24'h0, 24'h0);
		wr(8'h44, 16'hff00, RESP_OKAY);
		wr(8'h48, 16'h0012, RESP_OKAY);
		wr(8'h4c, 16'h34ff, RESP_OKAY);
		lat(1'b0, 6'h2a, 24'h3400ff, 24'hff1200);
		rdc(8'h44, 32'hff00, RESP_OKAY);
		wr(8'h50, 16'h8001, RESP_OKAY);
		wr(8'h54, 16'h7fff, RESP_OKAY);
		wr(8'h58, 16'hffff, RESP_OKAY);
		chk("offset_a", 32'h8001, 32'(offa));
		chk("offset_b", 32'h7fff, 32'(offb));
		chk("offset_c", 32'hffff, 32'(offc));
		// Slow master: clock enable frozen after the handshake, then the response held with bready low
		awaddr <= 8'h58;
		wdata <= 32'h0000_5a5a;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		@(posedge aclk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		ce <= 1'b0;
		repeat (4) @(posedge aclk);
		chk("frozen_bvalid", 32'h0, 32'(bvalid));
		chk("frozen_offset_c", 32'hffff, 32'(offc));
		ce <= 1'b1;
		repeat (3) @(posedge aclk);
		chk("held_bvalid", 32'h1, 32'(bvalid));
		chk("held_bresp", 32'(RESP_OKAY), 32'(bresp));
		chk("offset_c", 32'h5a5a, 32'(offc));
		bready <= 1'b1;
		@(posedge aclk);
		bready <= 1'b0;
		@(posedge aclk);
		sweep(1'b0);
		wr(8'h40, 16'h01c0, RESP_OKAY);
		lat(1'b1, 6'h0, 24'h3400ff, 24'hff1200);
		sweep(1'b1);
		aresetn <= 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		lat(1'b1, 6'h0, 24'h3400ff, 24'hff1200);
		rdc(8'h40, 32'h0, RESP_OKAY);
		wr(8'h50, 16'h0001, RESP_OKAY);
		lat(1'b1, 6'h0, 24'h3400ff, 24'hff1200);
		wr(8'h44, 16'h00aa, RESP_OKAY);
		lat(1'b0, 6'h0, 24'h0, 24'h0000aa);
		final_report();
	end
endmodule : low_power_detect_config_regs_tb
